// ### hdl/card_irq_pin_function_mux.sv
// Pin function mux for the shared interrupt, DMA, clock-run, ring and speaker pins.
// Assumes an APB master on ref_clk and card inputs synchronous to ref_clk.
//
// Overview of operation
// - IRQ3/IRQ4 pins as ISA or PCI INTA/INTB
// - IRQ7 pin becomes legacy DMA request
// - IRQ11 pin becomes input for DMA grant
// - Device control bits 2-1 pick IRQ9 mode
// - Serial mode carries all IRQs on one pin
// - Plain mode drives IRQ9 for card request
// - Offset 80h bit 0 enables open-drain clock-run
// - Offset 80h bit 7 picks IRQ10 or IRQ12
// - IRQ5 and IRQ14 carry card interrupts in ISA mode only
// - IRQ15 forwards card ring indicate when selected
// - Speaker mode outputs card audio
// - Card control picks speaker or suspend
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "irq_mux_defines.svh"
module card_irq_pin_function_mux
  import irq_mux_pkg::*;
#(
  parameter int IRQ_COUNT = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire card_in_t    card_in,
  input  wire logic        dma_request,
  output logic             legacy_dma_grant_in,
  input  wire logic        clkrun_request,
  input  wire logic        suspend_pin_in,
  output logic             suspend_mode,
  output logic             irq3_inta,
  output logic             irq4_intb,
  output logic             irq5,
  output logic             irq7_legacy_dma_request_out,
  output logic             irq9_plain,
  input  wire logic        serial_interrupt_pin_in,
  output logic             serial_interrupt_pin_out,
  output logic             serial_interrupt_pin_oe_n,
  output logic             irq10_out,
  output logic             irq10_oe_n,
  input  wire logic        irq11_in,
  output logic             irq11_out,
  output logic             irq11_oe_n,
  output logic             irq12_out,
  output logic             irq12_oe_n,
  output logic             irq14,
  output logic             ring_indicate_forward,
  output logic             card_audio_out,
  output logic             irq
);

  // Slot indexing and the pin map serve exactly eight requests
  if (IRQ_COUNT != 8) begin : g_count_check
    $error("IRQ_COUNT must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0]           system_control;
  logic [31:0]           device_control;
  logic [31:0]           card_control;
  logic [`ST_WIDTH-1:0]  irq_status;
  logic [`ST_WIDTH-1:0]  irq_mask;
  logic                  wr_en;
  logic                  rd_en;
  logic [`ST_WIDTH-1:0]  events;
  logic [`ST_WIDTH-1:0]  prev_src;
  logic [`ST_WIDTH-1:0]  src;
  irq9_mode_t            irq9_mode;

  // Offset match, used for both read and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `OFS_SYSTEM_CONTROL) | hit(a, `OFS_DEVICE_CONTROL) |
             hit(a, `OFS_CARD_CONTROL) | hit(a, `OFS_IRQ_STATUS) |
             hit(a, `OFS_IRQ_MASK) | hit(a, `OFS_PIN_STATE);
  endfunction : mapped

  // Zero-wait slave; unmapped access errors
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_en   = psel & penable & pwrite & mapped(paddr);
  assign rd_en   = psel & ~penable & ~pwrite;

  // Control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control <= `RESET_WORD;
      device_control <= `RESET_WORD;
      card_control   <= `RESET_WORD;
      irq_mask       <= '0;
    end else if (wr_en) begin
      if (hit(paddr, `OFS_SYSTEM_CONTROL)) system_control <= pwdata;
      if (hit(paddr, `OFS_DEVICE_CONTROL)) device_control <= pwdata;
      if (hit(paddr, `OFS_CARD_CONTROL))   card_control   <= pwdata;
      if (hit(paddr, `OFS_IRQ_MASK))       irq_mask       <= pwdata[`ST_WIDTH-1:0];
    end
  end

  assign irq9_mode = irq9_mode_t'(device_control[`DC_IRQ9_HI_BIT:`DC_IRQ9_LO_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Pin selects

  logic pci_int_mode;
  logic dma_req_mode;
  logic dma_gnt_mode;
  logic clkrun_en;
  logic clkrun_on_12;
  logic ring_mode;
  logic speaker_mode;
  logic serial_mode;
  logic card_any;

  assign pci_int_mode = system_control[`SC_PCI_INT_BIT];
  assign dma_req_mode = system_control[`SC_DMA_REQ_BIT];
  assign dma_gnt_mode = system_control[`SC_DMA_GNT_BIT];
  assign clkrun_en    = system_control[`SC_CLKRUN_EN_BIT];
  assign clkrun_on_12 = system_control[`SC_CLKRUN_SEL_BIT];
  assign ring_mode    = card_control[`CC_RING_EN_BIT];
  assign speaker_mode = card_control[`CC_SPEAKER_BIT];
  assign serial_mode  = (irq9_mode == IRQ9_SERIAL);
  assign card_any     = |card_in.irq;

  // Parallel outputs are silent in serial mode; the frame carries them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq3_inta                   <= 1'b0;
      irq4_intb                   <= 1'b0;
      irq5                        <= 1'b0;
      irq7_legacy_dma_request_out <= 1'b0;
      irq9_plain                  <= 1'b0;
      irq14                       <= 1'b0;
      ring_indicate_forward       <= 1'b0;
      card_audio_out              <= 1'b0;
      suspend_mode                <= 1'b0;
      legacy_dma_grant_in         <= 1'b0;
    end else begin
      // Same wire serves both styles; only the style of use differs
      irq3_inta <= ~serial_mode & card_in.irq[0];
      irq4_intb <= ~serial_mode & card_in.irq[1];
      irq5      <= ~serial_mode & ~pci_int_mode & card_in.irq[2];
      irq14     <= ~serial_mode & ~pci_int_mode & card_in.irq[6];
      irq7_legacy_dma_request_out <= dma_req_mode ? dma_request
                                   : (~serial_mode & card_in.irq[3]);
      irq9_plain <= (irq9_mode == IRQ9_PLAIN) & card_in.irq[4];
      ring_indicate_forward <= ring_mode ? card_in.ring
                             : (~serial_mode & card_in.irq[7]);
      card_audio_out <= speaker_mode & card_in.audio;
      suspend_mode   <= ~speaker_mode & suspend_pin_in;
      legacy_dma_grant_in <= dma_gnt_mode & irq11_in;
    end
  end

  // Clock-run pin is open drain: drives low only, enable low while driving
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq10_out  <= 1'b0;
      irq10_oe_n <= 1'b1;
      irq12_out  <= 1'b0;
      irq12_oe_n <= 1'b1;
      irq11_out  <= 1'b0;
      irq11_oe_n <= 1'b1;
    end else begin
      if (clkrun_en && !clkrun_on_12) begin
        irq10_out  <= 1'b0;
        irq10_oe_n <= ~clkrun_request;
      end else begin
        irq10_out  <= ~serial_mode & card_in.irq[5];
        irq10_oe_n <= 1'b0;
      end
      if (clkrun_en && clkrun_on_12) begin
        irq12_out  <= 1'b0;
        irq12_oe_n <= ~clkrun_request;
      end else begin
        irq12_out  <= ~serial_mode & ~pci_int_mode & card_any;
        irq12_oe_n <= 1'b0;
      end
      // Grant duty turns the pin round to an input
      irq11_out  <= ~dma_gnt_mode & ~serial_mode & card_in.irq[5];
      irq11_oe_n <= dma_gnt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial interrupt frame: start pulse, one slot per request, stop

  ser_state_t ser_state;
  logic [4:0] ser_count;
  logic [IRQ_COUNT-1:0] ser_latched;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_state                 <= SER_IDLE;
      ser_count                 <= '0;
      ser_latched               <= '0;
      serial_interrupt_pin_out  <= 1'b1;
      serial_interrupt_pin_oe_n <= 1'b1;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          serial_interrupt_pin_oe_n <= 1'b1;
          // Frame begins on any request change; a pin fight is avoided by idling
          if (serial_mode && (card_in.irq != ser_latched)) begin
            ser_state                 <= SER_START;
            ser_count                 <= 5'h01; // This cycle already drives low
            ser_latched               <= card_in.irq;
            serial_interrupt_pin_out  <= 1'b0;
            serial_interrupt_pin_oe_n <= 1'b0;
          end
        end
        SER_START: begin
          ser_count <= ser_count + 5'h01;
          if (ser_count == `SERIRQ_START_LEN - 5'h01) begin
            ser_state <= SER_SLOTS;
            ser_count <= '0;
          end
        end
        SER_SLOTS: begin
          // Low slot means request active
          serial_interrupt_pin_out <= ~ser_latched[ser_count[2:0]];
          ser_count <= ser_count + 5'h01;
          if (ser_count == 5'(IRQ_COUNT - 1)) begin
            ser_state <= SER_STOP;
            ser_count <= '0;
          end
        end
        SER_STOP: begin
          serial_interrupt_pin_out <= 1'b1;
          ser_count <= ser_count + 5'h01;
          if (ser_count == `SERIRQ_STOP_LEN - 5'h01) begin
            ser_state <= SER_IDLE;
          end
        end
        default: ser_state <= SER_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, rising edges of events; set wins over clear

  assign src = {card_any, card_in.ring, suspend_mode, legacy_dma_grant_in};
  assign events = src & ~prev_src;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_src   <= '0;
      irq_status <= '0;
    end else begin
      prev_src <= src;
      if (wr_en && hit(paddr, `OFS_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~pwdata[`ST_WIDTH-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data registered at setup, valid in access phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= '0;
      if (hit(paddr, `OFS_SYSTEM_CONTROL)) prdata <= system_control;
      if (hit(paddr, `OFS_DEVICE_CONTROL)) prdata <= device_control;
      if (hit(paddr, `OFS_CARD_CONTROL))   prdata <= card_control;
      if (hit(paddr, `OFS_IRQ_STATUS))     prdata <= {28'h0000000, irq_status};
      if (hit(paddr, `OFS_IRQ_MASK))       prdata <= {28'h0000000, irq_mask};
      if (hit(paddr, `OFS_PIN_STATE))      prdata <= {21'h00000, serial_interrupt_pin_in, ser_state,
                                                      src, ser_latched[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence gnt_mode_s;
    dma_gnt_mode && irq11_in;
  endsequence

  dma_grant_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gnt_mode_s |=> legacy_dma_grant_in) else $error("grant not taken");
  grant_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !dma_gnt_mode |=> !legacy_dma_grant_in) else $error("stray grant");
  grant_pin_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_gnt_mode |=> irq11_oe_n) else $error("irq11 driven in grant mode");
  dma_req_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_req_mode |=> irq7_legacy_dma_request_out == $past(dma_request))
    else $error("dma request wrong");
  clkrun_open_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkrun_en && !clkrun_on_12) |=> !irq10_out) else $error("clkrun drives high");
  clkrun_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkrun_en && clkrun_on_12 && clkrun_request) |=> !irq12_oe_n && irq10_oe_n == 1'b0)
    else $error("clkrun on wrong pin");
  irq9_plain_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (irq9_mode == IRQ9_PLAIN) && card_in.irq[4] |=> irq9_plain) else $error("irq9 missing");
  serial_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_mode |=> !irq9_plain && !irq5) else $error("parallel irq in serial");
  serial_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ser_state == SER_IDLE && serial_mode && card_in.irq != ser_latched)
    |=> (!serial_interrupt_pin_oe_n && !serial_interrupt_pin_out) [*4])
    else $error("bad start pulse");
  speaker_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speaker_mode |=> card_audio_out == $past(card_in.audio) && !suspend_mode)
    else $error("speaker path wrong");
  ring_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ring_mode |=> ring_indicate_forward == $past(card_in.ring)) else $error("ring lost");
  intab_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !serial_mode |=> irq3_inta == $past(card_in.irq[0])) else $error("irq3 wrong");
  isa_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pci_int_mode |=> !irq5 && !irq14) else $error("isa irq in pci mode");

endmodule : card_irq_pin_function_mux

// ### hdl/irq_mux_defines.svh
// Register offsets, field positions and reset values of the interrupt pin mux.
// Included by the mux alone; definitions only.
`ifndef IRQ_MUX_DEFINES_SVH
`define IRQ_MUX_DEFINES_SVH
`define OFS_SYSTEM_CONTROL 12'h080
`define OFS_DEVICE_CONTROL 12'h084
`define OFS_CARD_CONTROL   12'h088
`define OFS_IRQ_STATUS     12'h08C
`define OFS_IRQ_MASK       12'h090
`define OFS_PIN_STATE      12'h094
`define SC_CLKRUN_EN_BIT   0
`define SC_CLKRUN_SEL_BIT  7
`define SC_PCI_INT_BIT     1
`define SC_DMA_REQ_BIT     2
`define SC_DMA_GNT_BIT     3
`define DC_IRQ9_LO_BIT     1
`define DC_IRQ9_HI_BIT     2
`define CC_RING_EN_BIT     0
`define CC_SPEAKER_BIT     1
`define ST_WIDTH           4
`define ST_GRANT_BIT       0
`define ST_SUSPEND_BIT     1
`define ST_RING_BIT        2
`define ST_CARD_IRQ_BIT    3
`define SERIRQ_FRAME_LEN   5'h12
`define SERIRQ_START_LEN   5'h04
`define SERIRQ_STOP_LEN    5'h03
`define RESET_WORD         32'h0000_0000
`endif

// ### hdl/irq_mux_pkg.sv
// Types shared by the interrupt pin mux.
// Uses none of the macros in irq_mux_defines.svh.
package irq_mux_pkg;
  // IRQ9 pin modes, bits 2-1 of device control
  typedef enum logic [1:0] {
    IRQ9_PLAIN  = 2'b00,
    IRQ9_SERIAL = 2'b01,
    IRQ9_RSVD2  = 2'b10,
    IRQ9_RSVD3  = 2'b11
  } irq9_mode_t;
  // Serial interrupt frame sequencer
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_SLOTS = 2'b10,
    SER_STOP  = 2'b11
  } ser_state_t;
  // Card-side event inputs
  typedef struct packed {
    logic       ring;
    logic       audio;
    logic [7:0] irq;
  } card_in_t;
endpackage : irq_mux_pkg

// ### testbench/card_irq_pin_function_mux_tb.sv
// Self-checking bench for the interrupt pin mux, APB master and chipset model.
// Assumes zero-wait APB and pin outputs registered one cycle after inputs.
`timescale 1ns/1ps
module card_irq_pin_function_mux_tb;
  import irq_mux_pkg::*;
  logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata, sc, dc, cc;
  card_in_t    card_in = '0;
  logic        dma_request = 0, clkrun_request = 0, suspend_pin_in = 0;
  logic [1:0]  lat = '0;
  logic        pready, pslverr, rerr, irq11_line, ser_line;
  logic        legacy_dma_grant_in, suspend_mode, irq3_inta, irq4_intb, irq5;
  logic        irq7_legacy_dma_request_out, irq9_plain, irq14, irq;
  logic        ring_indicate_forward, card_audio_out;
  logic        serial_interrupt_pin_out, serial_interrupt_pin_oe_n;
  logic        irq10_out, irq10_oe_n, irq11_out, irq11_oe_n, irq12_out, irq12_oe_n;
  int          miscompares = 0, comparisons = 0, n;
  int          seed = 32'h8ecc7707;
  ////////////////////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk;
  card_irq_pin_function_mux card_irq_pin_function_mux_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .card_in(card_in),
    .dma_request(dma_request), .legacy_dma_grant_in(legacy_dma_grant_in),
    .clkrun_request(clkrun_request), .suspend_pin_in(suspend_pin_in),
    .suspend_mode(suspend_mode), .irq3_inta(irq3_inta), .irq4_intb(irq4_intb),
    .irq5(irq5), .irq7_legacy_dma_request_out(irq7_legacy_dma_request_out),
    .irq9_plain(irq9_plain), .serial_interrupt_pin_in(ser_line),
    .serial_interrupt_pin_out(serial_interrupt_pin_out),
    .serial_interrupt_pin_oe_n(serial_interrupt_pin_oe_n), .irq10_out(irq10_out),
    .irq10_oe_n(irq10_oe_n), .irq11_in(irq11_line), .irq11_out(irq11_out),
    .irq11_oe_n(irq11_oe_n), .irq12_out(irq12_out), .irq12_oe_n(irq12_oe_n),
    .irq14(irq14), .ring_indicate_forward(ring_indicate_forward),
    .card_audio_out(card_audio_out), .irq(irq));
  chipset_model chipset_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .lat(lat),
    .dma_req_line(irq7_legacy_dma_request_out), .gnt_out(irq11_out),
    .gnt_oe_n(irq11_oe_n), .ser_out(serial_interrupt_pin_out),
    .ser_oe_n(serial_interrupt_pin_oe_n), .gnt_line(irq11_line), .ser_line(ser_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk_pin
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("BAD %0t no ready", $time);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle
  // Pin roles follow the three control words
  task automatic check_pins();
    logic ser;
    ser = (dc[2:1] == 2'b01); // Serial mode silences the parallel lines
    chk_pin(irq3_inta, !ser & card_in.irq[0]);
    chk_pin(irq4_intb, !ser & card_in.irq[1]);
    chk_pin(irq5, !ser & !sc[1] & card_in.irq[2]);
    chk_pin(irq14, !ser & !sc[1] & card_in.irq[6]);
    chk_pin(irq7_legacy_dma_request_out, sc[2] ? dma_request : !ser & card_in.irq[3]);
    chk_pin(irq11_out, !sc[3] & !ser & card_in.irq[5]);
    chk_pin(irq10_out, (sc[0] & !sc[7]) ? 1'b0 : !ser & card_in.irq[5]);
    chk_pin(irq12_out, (sc[0] & sc[7]) ? 1'b0 : !ser & !sc[1] & |card_in.irq);
    chk_pin(legacy_dma_grant_in, sc[3] & irq11_line);
    if (sc[3]) chk_pin(irq11_oe_n, 1'b1);
    chk_pin(irq9_plain, dc[2:1] == 2'b00 && card_in.irq[4]);
    chk_pin(ring_indicate_forward, cc[0] ? card_in.ring : !ser & card_in.irq[7]);
    chk_pin(card_audio_out, cc[1] & card_in.audio);
    chk_pin(suspend_mode, !cc[1] & suspend_pin_in);
    chk_pin(irq10_oe_n, (sc[0] & !sc[7]) ? !clkrun_request : 1'b0);
    chk_pin(irq12_oe_n, (sc[0] & sc[7]) ? !clkrun_request : 1'b0);
  endtask : check_pins
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    chk_word({irq3_inta, irq4_intb, irq5, irq7_legacy_dma_request_out, irq9_plain,
      irq14, ring_indicate_forward, card_audio_out, irq, legacy_dma_grant_in}, '0);
    // Plain IRQ pins are driven at once; only the serial pin stays released
    chk_word({irq10_oe_n, irq11_oe_n, irq12_oe_n, serial_interrupt_pin_oe_n}, 32'h1);
    // Unmapped address: error, write dropped, reads zero
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
    chk_pin(rerr, 1'b1);
    apb(1'b0, 12'h0F0, '0);
    chk_word(rdata, '0);
    // Random modes and pin levels
    for (int i = 0; i < 60; i++) begin
      sc = $random(seed) & 32'h8F;
      dc = $random(seed) & 32'h6;
      cc = $random(seed) & 32'h3;
      apb(1'b1, `OFS_SYSTEM_CONTROL, sc);
      apb(1'b1, `OFS_DEVICE_CONTROL, dc);
      apb(1'b1, `OFS_CARD_CONTROL, cc);
      apb(1'b0, `OFS_SYSTEM_CONTROL, '0);
      chk_word(rdata, sc);
      apb(1'b0, `OFS_DEVICE_CONTROL, '0);
      chk_word(rdata, dc);
      @(posedge ref_clk);
      card_in <= $random(seed);
      dma_request <= $random(seed);
      clkrun_request <= $random(seed);
      suspend_pin_in <= $random(seed);
      lat <= $random(seed);
      settle();
      check_pins();
    end
    // Status events, masking and clearing
    @(posedge ref_clk);
    card_in <= '0;
    dma_request <= 1'b0;
    suspend_pin_in <= 1'b0;
    lat <= 2'h3;
    apb(1'b1, `OFS_CARD_CONTROL, '0);
    apb(1'b1, `OFS_SYSTEM_CONTROL, 32'hC);
    apb(1'b1, `OFS_IRQ_MASK, '0);
    settle();
    apb(1'b1, `OFS_IRQ_STATUS, 32'hF);
    card_in <= 10'h201;
    settle();
    apb(1'b0, `OFS_IRQ_STATUS, '0);
    chk_word(rdata, 32'hC);
    chk_pin(irq, 1'b0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h4);
    #1;
    chk_pin(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h4);
    #1;
    chk_pin(irq, 1'b0);
    // Slow grant from the chipset, plus suspend edge
    dma_request <= 1'b1;
    suspend_pin_in <= 1'b1;
    n = 0;
    while (legacy_dma_grant_in !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_pin(legacy_dma_grant_in, 1'b1);
    settle();
    apb(1'b0, `OFS_IRQ_STATUS, '0);
    chk_word(rdata, 32'hB);
    // Serial frame: start low, slot i low for a set request, stop high
    apb(1'b1, `OFS_DEVICE_CONTROL, 32'h2);
    repeat (30) @(posedge ref_clk);
    card_in <= 10'h0A5;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (serial_interrupt_pin_oe_n !== 1'b0 && n < 20);
    for (int k = 0; k < 15; k++) begin
      chk_pin(ser_line, k < 4 ? 1'b0 : k < 12 ? !card_in.irq[k - 4] : 1'b1);
      @(posedge ref_clk);
      #1;
    end
    chk_pin(serial_interrupt_pin_oe_n, 1'b1);
    end_sim();
  end
endmodule : card_irq_pin_function_mux_tb

// ### testbench/chipset_model.sv
// Chipset stand-in: grants DMA on the grant line, resolves the serial pin.
// Assumes the mux releases both pins (oe_n high) while not driving them.
`timescale 1ns/1ps
module chipset_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] lat,
  input  wire logic       dma_req_line,
  input  wire logic       gnt_out,
  input  wire logic       gnt_oe_n,
  input  wire logic       ser_out,
  input  wire logic       ser_oe_n,
  output logic            gnt_line,
  output logic            ser_line
);
  logic [3:0] hist;
  logic       grant;
  ////////////////////////////////////////////////////////////////////////////
  // Request history; lat picks a prompt or a slow grant
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hist <= '0;
    else hist <= {hist[2:0], dma_req_line};
  end
  assign grant = hist[lat];
  // Pull-up on the serial line, so a released pin reads high
  assign ser_line = ser_oe_n ? 1'b1 : ser_out;
  // Grant line is ours unless the mux drives it
  assign gnt_line = gnt_oe_n ? grant : gnt_out;
endmodule : chipset_model
